// ### hw/i2m_master.sv
// Function
// - counter reloads low seven bits, stops at zero
// - counter decrements on second and fourth phase
// - reload waits for clock sampled high
// - start request with lines high loads counter
// - timeout with lines high pulls data low
// - one more period, clear request, hold data
// - lines low or early clock fall collide
// - buffer write during start sets write collision
// - control writes ignored until start completes
// - restart pulls clock low, releases data period
// - both high one period, then data low
// - start seen early, event after timeout
// - restart request ignored while busy
// - restart collides on data low or clock fall
// - buffer write during restart sets write collision
// - buffer write sets full and starts transmit
// - bit after clock fall, low then high period
// - eighth fall clears full, releases data
// - ninth fall samples acknowledge into status
// - after ninth clock event, clock held low
// - reload selects standard, fast or fast-plus rate
`timescale 1ns/1ps
`default_nettype none
module i2m_master (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration from the core
  input wire logic masterEn,
  input wire logic [7:0] baudReload,
  // control writes
  input wire logic ctlWrite,
  input wire logic [4:0] ctlData,
  input wire logic txWrite,
  input wire logic [7:0] txData,
  output logic txReady,
  // flag clears
  input wire logic wcolClr,
  input wire logic bclClr,
  input wire logic evtClr,
  // status
  output i2m_pkg::i2m_stat_s status,
  // open-drain bus lines
  input wire i2m_pkg::i2m_line_s lineIn,
  output i2m_pkg::i2m_line_s lineOut,
  output i2m_pkg::i2m_line_s lineOe
);
  import i2m_pkg::*;
  // line synchronisers, first stage feeds only the second
  i2m_line_s syncA_r, syncB_r;
  // phase generator
  logic [3:0] div_r, div_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic tick;
  // engine state
  i2m_state_e st_r, st_nxt;
  logic [6:0] brg_r, brg_nxt;   // baud counter
  logic run_r, run_nxt;         // counter running
  logic [3:0] bit_r, bit_nxt;   // bit slot
  logic [7:0] shf_r, shf_nxt;   // outgoing byte
  i2m_line_s oe_r, oe_nxt;
  i2m_stat_s stat_nxt;
  logic tmo, idleLike, wrOk, bufValid, bufPop;
  logic [7:0] bufData;
  logic bufReady;
  logic sclS, sdaS;
  logic abort;
  logic evtSet; // an event flag set arrives this cycle

  assign sclS = syncB_r.scl;
  assign sdaS = syncB_r.sda;
  assign lineOe = oe_r;
  assign txReady = bufReady;

  // lines are open drain, the driven level is always low
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncA_r <= LINE_IDLE;
      syncB_r <= LINE_IDLE;
      lineOut <= LINE_RELEASED;
    end
    else
    begin
      syncA_r <= lineIn;
      syncB_r <= syncA_r;
      lineOut <= LINE_RELEASED;
    end
  end

  // instruction phases; ticks land on the second and fourth
  always_comb
  begin
    div_nxt = (div_r == PHASE_LAST) ? 4'h0 : div_r + 4'h1;
    phase_nxt = (div_r == PHASE_LAST) ? phase_r + 2'h1 : phase_r;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_r <= 4'h0;
      phase_r <= PHASE_RESET;
    end
    else
    begin
      div_r <= div_nxt;
      phase_r <= phase_nxt;
    end
  end
  assign tick = (div_r == PHASE_LAST) && phase_r[0];
  // rate follows from the reload value alone
  // a period ends when a tick finds the counter at zero
  assign tmo = run_r && tick && (brg_r == BRG_ZERO);

  // writes are only taken from an idle engine with no start, restart or full buffer pending, since nothing queues
  assign idleLike = (st_r == ST_IDLE) && !status.senBit && !status.rsenBit && !status.bufFull;
  // accepted write marks full and feeds the shifter
  assign wrOk = txWrite && idleLike && bufReady && masterEn;
  assign bufPop = (st_r == ST_IDLE) && !status.senBit && !status.rsenBit;

  i2m_txbuf u_buf (
    .clk(clk),
    .rstn(rstn),
    .inValid(wrOk),
    .inData(txData),
    .inReady(bufReady),
    .outValid(bufValid),
    .outData(bufData),
    .outReady(bufPop)
  );

  // engine: counter, sequences, flags
  always_comb
  begin
    st_nxt = st_r;
    brg_nxt = brg_r;
    run_nxt = run_r;
    bit_nxt = bit_r;
    shf_nxt = shf_r;
    oe_nxt = oe_r;
    stat_nxt = status;
    abort = 1'b0;
    // count down to zero then stop
    if (run_r && tick && (brg_r != BRG_ZERO))
      brg_nxt = brg_r - 7'h01;
    if (tmo)
      run_nxt = 1'b0;
    // write refused while a start or restart runs
    if (txWrite && masterEn && !wrOk)
      stat_nxt.write_collision_flag = 1'b1;
    // control accepted only from a quiet engine
    // restart never taken while busy; start wins a tie
    if (ctlWrite && idleLike && masterEn)
    begin
      stat_nxt.senBit = ctlData[CTL_SEN];
      stat_nxt.rsenBit = ctlData[CTL_RESTART_REQUEST_BIT] && !ctlData[CTL_SEN];
    end
    // event sets below are gathered apart, so a clear cannot swallow a repeated set
    stat_nxt.evt = 1'b0;
    case (st_r)
      ST_IDLE:
      begin
        if (status.senBit)
        begin
          // both lines high, load and count
          if (sclS && sdaS)
          begin
            brg_nxt = baudReload[6:0];
            run_nxt = 1'b1;
            st_nxt = ST_S_WAIT;
          end
          else if (!sclS && !sdaS)
            abort = 1'b1;
        end
        else if (status.rsenBit)
        begin
          oe_nxt.scl = 1'b1;
          st_nxt = ST_R_LOW;
        end
        else if (bufValid)
        begin
          // byte goes out most significant first, address then direction
          shf_nxt = bufData;
          bit_nxt = BIT_FIRST;
          oe_nxt.scl = 1'b1;
          brg_nxt = baudReload[6:0];
          run_nxt = 1'b1;
          st_nxt = ST_TX_LOW;
        end
      end
      ST_S_WAIT:
      begin
        // clock or data fell before data was driven
        if (!sclS || !sdaS)
          abort = 1'b1;
        else if (tmo)
        begin
          oe_nxt.sda = 1'b1;
          stat_nxt.startSeen = 1'b1;
          brg_nxt = baudReload[6:0];
          run_nxt = 1'b1;
          st_nxt = ST_S_HOLD;
        end
      end
      ST_S_HOLD:
      begin
        // second period, then request clears and data stays low
        if (tmo)
        begin
          stat_nxt.senBit = 1'b0;
          stat_nxt.evt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      ST_R_LOW:
      begin
        // clock seen low, release data for a period
        if (!sclS)
        begin
          oe_nxt.sda = 1'b0;
          brg_nxt = baudReload[6:0];
          run_nxt = 1'b1;
          st_nxt = ST_R_REL;
        end
      end
      ST_R_REL:
      begin
        if (tmo)
        begin
          if (sdaS)
          begin
            oe_nxt.scl = 1'b0;
            st_nxt = ST_R_SCLH;
          end
          else
            abort = 1'b1;
        end
      end
      ST_R_SCLH:
      begin
        // held clock keeps the counter waiting
        if (sclS)
        begin
          if (!sdaS)
            abort = 1'b1;
          else
          begin
            brg_nxt = baudReload[6:0];
            run_nxt = 1'b1;
            st_nxt = ST_R_HIGH;
          end
        end
      end
      ST_R_HIGH:
      begin
        // clock fell before data went low
        if (!sclS)
          abort = 1'b1;
        else if (tmo)
        begin
          oe_nxt.sda = 1'b1;
          brg_nxt = baudReload[6:0];
          run_nxt = 1'b1;
          st_nxt = ST_R_SDAL;
        end
      end
      ST_R_SDAL:
      begin
        // start seen on the lines, event only at timeout
        if (sclS && !sdaS)
          stat_nxt.startSeen = 1'b1;
        // request clears, counter left unloaded, data low
        if (tmo)
        begin
          stat_nxt.rsenBit = 1'b0;
          stat_nxt.evt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      ST_TX_LOW:
      begin
        // bit changes one cycle after the clock went low
        oe_nxt.sda = (bit_r != ACK_SLOT) && !shf_r[7];
        if (tmo)
        begin
          oe_nxt.scl = 1'b0;
          st_nxt = ST_TX_HI;
        end
      end
      ST_TX_HI:
      begin
        // reload only once the clock reads high
        if (!run_r && !tmo && sclS)
        begin
          brg_nxt = baudReload[6:0];
          run_nxt = 1'b1;
        end
        else if (tmo)
        begin
          // high period over, clock low again
          oe_nxt.scl = 1'b1;
          if (bit_r == ACK_SLOT)
          begin
            // acknowledge sampled at the ninth fall
            stat_nxt.ack_received_status = sdaS;
            // event, counter off, clock low, data floating
            stat_nxt.evt = 1'b1;
            oe_nxt.sda = 1'b0;
            st_nxt = ST_IDLE;
          end
          else
          begin
            bit_nxt = bit_r + 4'h1;
            shf_nxt = {shf_r[6:0], 1'b0};
            // eighth fall frees data and empties the buffer flag
            if (bit_r == ACK_SLOT - 4'h1)
            begin
              stat_nxt.bufFull = 1'b0;
              oe_nxt.sda = 1'b0;
            end
            brg_nxt = baudReload[6:0];
            run_nxt = 1'b1;
            st_nxt = ST_TX_LOW;
          end
        end
      end
      default:
        st_nxt = ST_IDLE;
    endcase
    if (wrOk)
      stat_nxt.bufFull = 1'b1;
    // any collision abandons the sequence and frees the lines
    if (abort)
    begin
      stat_nxt.bcl = 1'b1;
      stat_nxt.senBit = 1'b0;
      stat_nxt.rsenBit = 1'b0;
      stat_nxt.bufFull = 1'b0;
      oe_nxt = LINE_RELEASED;
      run_nxt = 1'b0;
      st_nxt = ST_IDLE;
    end
    // leaving master mode clears the requests, full and start-seen flags and releases the bus
    if (!masterEn)
    begin
      stat_nxt.senBit = 1'b0;
      stat_nxt.rsenBit = 1'b0;
      stat_nxt.bufFull = 1'b0;
      stat_nxt.startSeen = 1'b0;
      oe_nxt = LINE_RELEASED;
      run_nxt = 1'b0;
      st_nxt = ST_IDLE;
    end
    // software clears lose to a same-cycle set
    stat_nxt.write_collision_flag = stat_nxt.write_collision_flag && !(wcolClr && !(txWrite && masterEn && !wrOk));
    stat_nxt.bcl = stat_nxt.bcl && !(bclClr && !abort);
    evtSet = stat_nxt.evt;
    stat_nxt.evt = evtSet || (status.evt && !evtClr);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= ST_IDLE;
      brg_r <= BRG_ZERO;
      run_r <= 1'b0;
      bit_r <= BIT_FIRST;
      shf_r <= BYTE_RESET;
      oe_r <= LINE_RELEASED;
      status <= STAT_RESET;
    end
    else
    begin
      st_r <= st_nxt;
      brg_r <= brg_nxt;
      run_r <= run_nxt;
      bit_r <= bit_nxt;
      shf_r <= shf_nxt;
      oe_r <= oe_nxt;
      status <= stat_nxt;
    end
  end

  // checks
  a_brg_load: assert property (@(posedge clk) disable iff (!rstn)
    $rose(run_r) |-> brg_r == $past(baudReload[6:0])) else $error("counter load wrong");
  a_tick_spacing: assert property (@(posedge clk) disable iff (!rstn)
    tick |=> !tick [*8]) else $error("ticks too close");
  a_tx_hi_wait: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == ST_TX_HI && !run_r && !sclS) |=> !run_r) else $error("reload under low clock");
  a_start_data_low: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == ST_S_WAIT && tmo && sclS && sdaS && masterEn) |=> oe_r.sda && status.startSeen)
    else $error("start edge missing");
  a_start_done: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == ST_S_HOLD && tmo && masterEn) |=> !status.senBit && oe_r.sda && !run_r)
    else $error("start not completed");
  a_start_collide: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == ST_S_WAIT && !sclS && masterEn) |=> status.bcl && st_r == ST_IDLE && !oe_r.sda)
    else $error("start collision missed");
  a_write_collision_flag_start: assert property (@(posedge clk) disable iff (!rstn)
    (txWrite && masterEn && status.senBit) |=> status.write_collision_flag && $stable(u_buf.cnt_r))
    else $error("write during start taken");
  a_restart_request_bit_busy: assert property (@(posedge clk) disable iff (!rstn)
    (ctlWrite && st_r != ST_IDLE) |=> !$rose(status.rsenBit)) else $error("restart queued");
  a_bf_clear: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == ST_TX_HI && tmo && bit_r == 4'h7 && masterEn) |=> !status.bufFull && !oe_r.sda)
    else $error("eighth fall wrong");
  a_ack_sample: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == ST_TX_HI && tmo && bit_r == ACK_SLOT && masterEn)
    |=> status.ack_received_status == $past(sdaS) && status.evt && oe_r.scl) else $error("ack not taken");
  c_start: cover property (@(posedge clk) disable iff (!rstn) $fell(status.senBit) && !status.bcl);
  c_restart: cover property (@(posedge clk) disable iff (!rstn) $fell(status.rsenBit));
  c_byte: cover property (@(posedge clk) disable iff (!rstn) $fell(status.bufFull));
  c_collide: cover property (@(posedge clk) disable iff (!rstn) $rose(status.bcl));
endmodule : i2m_master
`default_nettype wire

// ### hw/i2m_txbuf.sv
`timescale 1ns/1ps
`default_nettype none
module i2m_txbuf (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // filling side
  input wire logic inValid,
  input wire logic [i2m_pkg::BUF_W-1:0] inData,
  output logic inReady,
  // draining side
  output logic outValid,
  output logic [i2m_pkg::BUF_W-1:0] outData,
  input wire logic outReady
);
  import i2m_pkg::*;
  logic [BUF_W-1:0] mem [BUF_DEPTH];  // storage
  logic wp_r, wp_nxt;                 // write slot
  logic rp_r, rp_nxt;                 // read slot
  logic [1:0] cnt_r, cnt_nxt;         // words held
  logic push, pop;
  // ready is a plain inverse of full decoded from the count, so the filler sees honest back-pressure
  assign inReady = (cnt_r != 2'(BUF_DEPTH));
  assign outValid = (cnt_r != 2'h0);
  assign outData = mem[rp_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  // pointer and count update
  always_comb
  begin
    wp_nxt = push ? ~wp_r : wp_r;
    rp_nxt = pop ? ~rp_r : rp_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  // data slots carry no reset, only valid words are ever read
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wp_r] <= inData;
    end
  end
endmodule : i2m_txbuf
`default_nettype wire

// ### inc/i2m_pkg.sv
`default_nettype none
package i2m_pkg;
  // timing base: core clock and instruction cycle
  localparam int CLK_NS = 5;
  localparam int TCY_NS = 200;
  // core clocks per instruction phase, four phases per cycle
  localparam int PHASE_CLKS = TCY_NS / 4 / CLK_NS;
  localparam logic [3:0] PHASE_LAST = 4'(PHASE_CLKS - 1);
  localparam logic [1:0] PHASE_RESET = 2'h0;
  // serial clock rates reachable through the reload value
  localparam int RATE_STD_HZ = 100000;
  localparam int RATE_FAST_HZ = 400000;
  localparam int RATE_FMP_HZ = 1000000;
  // reload for a rate: one counter period is half a serial clock, two ticks per cycle
  function automatic logic [6:0] rate_reload(input int hz);
    rate_reload = 7'((1000000000 / hz / 2) / (TCY_NS / 2) - 1);
  endfunction : rate_reload
  localparam logic [6:0] RELOAD_STD = rate_reload(RATE_STD_HZ);
  localparam logic [6:0] RELOAD_FAST = rate_reload(RATE_FAST_HZ);
  localparam logic [6:0] RELOAD_FMP = rate_reload(RATE_FMP_HZ);
  localparam logic [6:0] BRG_ZERO = 7'h00;
  // master control write bit positions
  localparam int CTL_SEN = 0;
  localparam int CTL_RESTART_REQUEST_BIT = 1;
  // status positions as the core sees them
  localparam int STAT_START_POS = 3;
  localparam int CTL_ACK_POS = 6;
  // bit counter: index 8 is the acknowledge slot
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // two-entry transmit buffer
  localparam int BUF_W = 8;
  localparam int BUF_DEPTH = 2;
  // state encodings, one-hot
  typedef enum logic [9:0] {
    ST_IDLE   = 10'h001,
    ST_S_WAIT = 10'h002,
    ST_S_HOLD = 10'h004,
    ST_R_LOW  = 10'h008,
    ST_R_REL  = 10'h010,
    ST_R_SCLH = 10'h020,
    ST_R_HIGH = 10'h040,
    ST_R_SDAL = 10'h080,
    ST_TX_LOW = 10'h100,
    ST_TX_HI  = 10'h200
  } i2m_state_e;
  // the two bus lines travel together
  typedef struct packed {
    logic scl;
    logic sda;
  } i2m_line_s;
  // status bits shown to the core
  typedef struct packed {
    logic senBit;
    logic rsenBit;
    logic ack_received_status;
    logic startSeen;
    logic bufFull;
    logic write_collision_flag;
    logic bcl;
    logic evt;
  } i2m_stat_s;
  localparam i2m_line_s LINE_IDLE = 2'b11;
  localparam i2m_line_s LINE_RELEASED = 2'b00;
  localparam i2m_stat_s STAT_RESET = 8'h00;
endpackage : i2m_pkg
`default_nettype wire

// ### tb/i2m_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2m_slave_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // behaviour chosen by the bench
  input wire logic ackOn,
  input wire logic jamSda,
  input wire logic jamScl,
  input wire logic [8:0] stretchClks,
  // pulls on the lines and what was seen
  output logic sclLow,
  output logic sdaLow,
  output logic inAck,
  output logic [7:0] rxByte,
  output logic [7:0] nStarts
);
  logic sclQ, sdaQ; // lines one clock ago
  logic [3:0] rises; // clock highs since the last start or ninth fall
  logic [7:0] shiftR; // bits gathered so far
  logic [8:0] holdCnt; // remaining stretch cycles
  assign sdaLow = (inAck & ackOn) | jamSda;
  // stretching keeps the clock low past the master's own low period
  assign sclLow = (holdCnt != 9'h000) | jamScl;
  // edge detection on the sampled lines, one clock late like a real slave
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {sclQ, sdaQ} <= 2'h3;
      rises <= 4'h0;
      shiftR <= 8'h00;
      holdCnt <= 9'h000;
      inAck <= 1'b0;
      rxByte <= 8'h00;
      nStarts <= 8'h00;
    end
    else
    begin
      sclQ <= scl;
      sdaQ <= sda;
      if (holdCnt != 9'h000)
        holdCnt <= holdCnt - 9'h001;
      if (sclQ && scl && sdaQ && !sda)
      begin
        rises <= 4'h0;
        inAck <= 1'b0;
        nStarts <= nStarts + 8'h01;
      end
      else if (!sclQ && scl)
      begin
        rises <= rises + 4'h1;
        if (rises < 4'h8)
          shiftR <= {shiftR[6:0], sda};
      end
      else if (sclQ && !scl)
      begin
        if (stretchClks != 9'h000)
          holdCnt <= stretchClks;
        if (rises == 4'h8)
        begin
          inAck <= 1'b1;
          rxByte <= shiftR;
        end
        // ninth fall ends the slot and the byte
        if (rises == 4'h9)
        begin
          inAck <= 1'b0;
          rises <= 4'h0;
        end
      end
    end
  end
endmodule : i2m_slave_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import i2m_pkg::*;
  // design side
  logic clk, rstn, masterEn, ctlWrite, txWrite, wcolClr, bclClr, evtClr, txReady;
  logic [7:0] baudReload, txData;
  logic [4:0] ctlData;
  i2m_stat_s status;
  i2m_line_s lineIn, lineOut, lineOe;
  // partner knobs and observations
  logic ackOn, jamSda, jamScl, sclLow, sdaLow, inAck;
  logic [8:0] stretchClks;
  logic [7:0] rxByte, nStarts;
  // open-drain wires: pulled up unless someone pulls low
  wire logic sclW = (lineOe.scl ? lineOut.scl : 1'b1) & ~sclLow;
  wire logic sdaW = (lineOe.sda ? lineOut.sda : 1'b1) & ~sdaLow;
  int n_fail = 0;
  int check_count = 0;
  int hiCnt = 0; // length of the current clock high phase
  int lastHigh = 0;
  // reloads for the three rates, slowest first
  logic [7:0] rl [3] = '{8'h31, 8'h0b, 8'h04};
  assign lineIn = {sclW, sdaW};
  i2m_master i_i2m_master (.clk(clk), .rstn(rstn), .masterEn(masterEn),
    .baudReload(baudReload), .ctlWrite(ctlWrite), .ctlData(ctlData), .txWrite(txWrite),
    .txData(txData), .txReady(txReady), .wcolClr(wcolClr), .bclClr(bclClr),
    .evtClr(evtClr), .status(status), .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe));
  i2m_slave_model i_i2m_slave_model (.clk(clk), .rstn(rstn), .scl(sclW), .sda(sdaW),
    .ackOn(ackOn), .jamSda(jamSda), .jamScl(jamScl), .stretchClks(stretchClks),
    .sclLow(sclLow), .sdaLow(sdaLow), .inAck(inAck), .rxByte(rxByte), .nStarts(nStarts));
  // 200 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // measure each clock high phase on the wire
  always @(posedge clk)
  begin
    if (sclW)
      hiCnt <= hiCnt + 1;
    else
    begin
      if (hiCnt != 0)
        lastHigh <= hiCnt;
      hiCnt <= 0;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask : chkb
  // inputs move 1 ns after the edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // control write; the answer is visible right after the edge that takes it
  task automatic ctl(input logic [4:0] d);
    ctlData = d;
    ctlWrite = 1'b1;
    step(1);
    ctlWrite = 1'b0;
    step(1);
  endtask : ctl
  task automatic tx(input logic [7:0] b);
    txData = b;
    txWrite = 1'b1;
    step(1);
    txWrite = 1'b0;
    step(1);
  endtask : tx
  // sticky flags are cleared together
  task automatic clr();
    {wcolClr, bclClr, evtClr} = 3'h7;
    step(1);
    {wcolClr, bclClr, evtClr} = 3'h0;
  endtask : clr
  // disabling releases the lines held low after a byte
  task automatic reenable();
    masterEn = 1'b0;
    step(4);
    masterEn = 1'b1;
    step(4);
  endtask : reenable
  // bounded wait for the event or a collision
  task automatic wait_evt();
    int i;
    i = 0;
    while (status.evt !== 1'b1 && status.bcl !== 1'b1 && i < 30000)
    begin
      step(1);
      i++;
    end
    chkb("event within bound", 1'b1, i < 30000);
  endtask : wait_evt
  // one byte to the slave model with the given answer
  task automatic byte_seq(input logic [7:0] b, input logic ack);
    int i;
    int r;
    r = int'(baudReload[6:0]);
    ackOn = ack;
    clr();
    tx(b);
    chkb("buffer full", 1'b1, status.bufFull);
    chkb("buffer ready", 1'b1, txReady);
    ctl(5'h02);
    chkb("restart while busy", 1'b0, status.rsenBit);
    tx(~b);
    chkb("write while busy", 1'b1, status.write_collision_flag);
    i = 0;
    while (inAck !== 1'b1 && i < 30000)
    begin
      step(1);
      i++;
    end
    chkb("ack slot within bound", 1'b1, i < 30000);
    step(2);
    chkb("buffer cleared", 1'b0, status.bufFull);
    chkb("data released", 1'b0, lineOe.sda);
    wait_evt();
    chk("byte on wire", b, rxByte);
    chkb("ack status", ~ack, status.ack_received_status);
    chkb("byte event", 1'b1, status.evt);
    chkb("high time", 1'b1, lastHigh >= r * 20 && lastHigh <= r * 20 + 28);
    step(200);
    chk("clock held low", 8'h02, {6'h00, lineOe});
  endtask : byte_seq
  // watchdog sized well above the longest expected run
  initial
  begin
    #400000;
    n_fail++;
    $display("mismatch watchdog expected done seen hang");
    report_and_stop();
  end
  initial
  begin
    logic [7:0] n0;
    int i;
    {rstn, masterEn, ctlWrite, txWrite, wcolClr, bclClr, evtClr} = 7'h00;
    {ackOn, jamSda, jamScl} = 3'h4;
    {baudReload, ctlData, txData, stretchClks} = '0;
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    step(3);
    // start, wait event, address, check acknowledge, per rate
    for (int k = 0; k < 3; k++)
    begin
      baudReload = rl[k];
      reenable();
      clr();
      ctl(5'h01);
      chkb("start request", 1'b1, status.senBit);
      tx(8'h55);
      chkb("write in start", 1'b1, status.write_collision_flag);
      chkb("buffer kept", 1'b0, status.bufFull);
      ctl(5'h02);
      chkb("restart in start", 1'b0, status.rsenBit);
      wait_evt();
      chkb("start seen", 1'b1, status.startSeen);
      chkb("start done", 1'b0, status.senBit);
      chk("lines after start", 8'h01, {6'h00, lineOe});
      chk("drive level", 8'h00, {6'h00, lineOut});
      byte_seq(8'ha4, 1'b1);
    end
    // refused byte with a stretching slave
    reenable();
    clr();
    ctl(5'h03);
    chkb("start wins tie", 1'b0, status.rsenBit);
    wait_evt();
    stretchClks = 9'h12c;
    byte_seq(8'h3c, 1'b0);
    stretchClks = 9'h000;
    // repeated start from the held clock
    clr();
    n0 = nStarts;
    ctl(5'h02);
    chkb("restart request", 1'b1, status.rsenBit);
    tx(8'h11);
    chkb("write in restart", 1'b1, status.write_collision_flag);
    chkb("buffer kept", 1'b0, status.bufFull);
    i = 0;
    while (nStarts === n0 && i < 30000)
    begin
      step(1);
      i++;
    end
    chkb("restart within bound", 1'b1, i < 30000);
    chkb("event held back", 1'b0, status.evt);
    wait_evt();
    chk("restart on wire", n0 + 8'h01, nStarts);
    chkb("restart done", 1'b0, status.rsenBit);
    chk("lines after restart", 8'h01, {6'h00, lineOe});
    byte_seq(8'h5a, 1'b1);
    // repeated start with data held low by another party
    clr();
    jamSda = 1'b1;
    ctl(5'h02);
    wait_evt();
    chkb("restart collision", 1'b1, status.bcl);
    chkb("restart aborted", 1'b0, status.rsenBit);
    chk("restart lines free", 8'h00, {6'h00, lineOe});
    jamSda = 1'b0;
    // start against low lines, then against an early clock fall
    for (int k = 0; k < 2; k++)
    begin
      reenable();
      clr();
      {jamSda, jamScl} = (k == 0) ? 2'h3 : 2'h0;
      step(4);
      ctl(5'h01);
      step(20);
      jamScl = 1'b1;
      wait_evt();
      chkb("start collision", 1'b1, status.bcl);
      chkb("start aborted", 1'b0, status.senBit);
      chk("start lines free", 8'h00, {6'h00, lineOe});
      {jamSda, jamScl} = 2'h0;
    end
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
